// ### src/dlnr_pkg.sv
`default_nettype none
package dlnr_pkg;
    localparam int DATA_W = 9;
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;

    // register indices; the byte address is four times the index
    localparam logic [5:0] IDX_LIM_TIMING = 6'h18;
    localparam logic [5:0] IDX_LIM_THRESH_BOOST = 6'h19;
    localparam logic [5:0] IDX_NOTCH_A0_HIGH_CTRL = 6'h1B;
    localparam logic [5:0] IDX_NOTCH_A0_LOW = 6'h1C;
    localparam logic [5:0] IDX_NOTCH_A1_HIGH = 6'h1D;
    localparam logic [5:0] IDX_NOTCH_A1_LOW = 6'h1E;
    localparam int NOTCH_REGS = 4;

    // field positions
    localparam int LIM_EN_BIT = 8;
    localparam int DECAY_LSB = 4;
    localparam int ATTACK_LSB = 0;
    localparam int THRESH_LSB = 4;
    localparam int BOOST_LSB = 0;
    localparam int UPDATE_BIT = 8;
    localparam int NOTCH_EN_BIT = 7;
    localparam int COEFF_PART_W = 7;

    // reset values
    localparam logic [8:0] RST_LIM_TIMING = 9'h032;
    localparam logic [8:0] RST_LIM_THRESH_BOOST = 9'h000;
    localparam logic [7:0] RST_NOTCH = 8'h00;

    // storable bits of each register
    localparam logic [8:0] MASK_LIM_TIMING = 9'h1FF;
    localparam logic [8:0] MASK_LIM_THRESH_BOOST = 9'h07F;
    localparam logic [7:0] MASK_NOTCH_FIRST = 8'hFF;
    localparam logic [7:0] MASK_NOTCH_OTHER = 8'h7F;

    // timing at the reference sample rate, converted to samples
    localparam longint REF_RATE_HZ = 44100;
    localparam longint DECAY_BASE_NS = 544000;
    localparam longint ATTACK_BASE_NS = 68000;
    localparam logic [15:0] DECAY_BASE_SAMPLES = 16'((DECAY_BASE_NS * REF_RATE_HZ + 500000000) / 1000000000);
    localparam logic [15:0] ATTACK_BASE_SAMPLES = 16'((ATTACK_BASE_NS * REF_RATE_HZ + 500000000) / 1000000000);
    localparam logic [3:0] TIME_SAT_CODE = 4'hB;

    localparam logic [2:0] THRESH_SAT_CODE = 3'h4;
    localparam logic [3:0] THRESH_BASE_DB = 4'h1;
    localparam logic [3:0] THRESH_FLOOR_DB = 4'h6;
    localparam logic [3:0] BOOST_MAX_CODE = 4'hC;

    typedef struct packed {
        logic enable;
        logic [3:0] decay_code;
        logic [3:0] attack_code;
        logic [2:0] threshold_code;
        logic [3:0] boost_code;
    } dlnr_lim_cfg_t;

    typedef struct packed {
        logic enable;
        logic [15:0] decay_samples;
        logic [15:0] attack_samples;
        logic [3:0] threshold_atten_db;
        logic [3:0] boost_ceiling_db;
        logic [3:0] fixed_gain_db;
    } dlnr_lim_out_t;

    typedef struct packed {
        logic enable;
        logic [13:0] a0;
        logic [13:0] a1;
    } dlnr_notch_t;

    function automatic logic [15:0] dlnr_scale(input logic [15:0] base, input logic [3:0] code);
        logic [3:0] sh;
        sh = (code > TIME_SAT_CODE) ? TIME_SAT_CODE : code;
        return base << sh;
    endfunction : dlnr_scale

    function automatic dlnr_lim_out_t dlnr_decode(input dlnr_lim_cfg_t cfg);
        dlnr_lim_out_t res;
        logic [3:0] boost;
        boost = (cfg.boost_code > BOOST_MAX_CODE) ? BOOST_MAX_CODE : cfg.boost_code;
        res.enable = cfg.enable;
        res.decay_samples = dlnr_scale(DECAY_BASE_SAMPLES, cfg.decay_code);
        res.attack_samples = dlnr_scale(ATTACK_BASE_SAMPLES, cfg.attack_code);
        res.threshold_atten_db = (cfg.threshold_code > THRESH_SAT_CODE) ? THRESH_FLOOR_DB :
            4'({1'b0, cfg.threshold_code}) + THRESH_BASE_DB;
        res.boost_ceiling_db = boost;
        res.fixed_gain_db = cfg.enable ? 4'h0 : boost;
        return res;
    endfunction : dlnr_decode

    localparam dlnr_lim_out_t RST_LIM_OUT = dlnr_decode(dlnr_lim_cfg_t'({RST_LIM_TIMING, RST_LIM_THRESH_BOOST[6:0]}));
endpackage : dlnr_pkg
`default_nettype wire

// ### src/dlnr_lim_decode.sv
`default_nettype none
module dlnr_lim_decode (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire dlnr_pkg::dlnr_lim_cfg_t cfg_i,
    output dlnr_pkg::dlnr_lim_out_t lim_o
);
    import dlnr_pkg::*;

    // registered so the signal path sees glitch-free settings
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lim_o <= RST_LIM_OUT;
        end else begin
            lim_o <= dlnr_decode(cfg_i);
        end
    end
endmodule : dlnr_lim_decode
`default_nettype wire

// ### src/dlnr_notch_bank.sv
`default_nettype none
module dlnr_notch_bank (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] wr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic update_i,
    output logic [3:0][7:0] pending_o,
    output dlnr_pkg::dlnr_notch_t active_o
);
    import dlnr_pkg::*;

    logic [3:0][7:0] pending;
    logic [3:0][7:0] active;
    logic [3:0][7:0] next_pending;

    always_comb begin
        next_pending = pending;
        for (int i = 0; i < NOTCH_REGS; i++) begin
            if (wr_i[i]) begin
                next_pending[i] = wr_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending <= {NOTCH_REGS{RST_NOTCH}};
        end else begin
            pending <= next_pending;
        end
    end

    // the whole set moves at once, including the value written now
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            active <= {NOTCH_REGS{RST_NOTCH}};
        end else if (update_i && |wr_i) begin
            active <= next_pending;
        end
    end

    assign pending_o = pending;
    assign active_o = '{enable: active[0][NOTCH_EN_BIT],
                        a0: {active[0][COEFF_PART_W-1:0], active[1][COEFF_PART_W-1:0]},
                        a1: {active[2][COEFF_PART_W-1:0], active[3][COEFF_PART_W-1:0]}};
endmodule : dlnr_notch_bank
`default_nettype wire

// ### src/dlnr_regs.sv
// Operation
// - decay time doubles per code; code 0 is 0.544 ms, default code 3
// - decay codes 9 and 10 give 278 and 557 ms; 11 upward saturate
// - attack doubles per code from 68 us; codes 11 upward saturate at 139 ms
// - attack resets to code 2; timing register reads 0x032 after reset
// - threshold -1 dB at code 0, 1 dB steps to -5 dB; above is -6 dB
// - boost 0 to 12 dB in 1 dB steps; codes above 12 reserved
// - limiter off applies the programmed boost as fixed extra gain
// - single enable bit turns the playback limiter off or on
// - notch enable bit turns the notch filter off or on
// - A0 coefficient bits 13:7 in first register, 6:0 in second
// - A1 coefficient bits 13:7 held in third notch register
// - A1 bits 6:0 in fourth notch register, reset value zero
// - write with update set applies it and all pending notch values together
// - write with update clear stays pending until the next update write
// - update bit is write-only and never stored
// - threshold/boost register and second, third notch registers reset to zero
`default_nettype none
module dlnr_regs (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [dlnr_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [dlnr_pkg::BUS_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [dlnr_pkg::BUS_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output dlnr_pkg::dlnr_lim_out_t lim_o,
    output dlnr_pkg::dlnr_notch_t notch_o
);
    import dlnr_pkg::*;

    logic ack;
    logic req;
    logic accept_wr;
    logic [5:0] idx;
    logic mapped;
    logic notch_hit;
    logic [1:0] notch_sel;
    logic [8:0] cur_value;
    logic [8:0] merged;
    logic update_req;
    logic [8:0] lim_timing;
    logic [8:0] lim_thresh_boost;
    logic [3:0] notch_wr;
    logic [7:0] notch_wdata;
    logic [3:0][7:0] notch_pending;
    dlnr_lim_cfg_t lim_cfg;

    // byte lane 0 carries bits 7:0, lane 1 carries bit 8
    function automatic logic [8:0] merge_lanes(input logic [8:0] old, input logic [31:0] wdata,
                                              input logic [3:0] be);
        logic [8:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            res[8] = wdata[8];
        end
        return res;
    endfunction : merge_lanes

    // bus slave: one wait cycle on every access, so the read mux has a full cycle
    assign req = avs_read_i || avs_write_i;
    assign avs_waitrequest_o = req && !ack;
    assign accept_wr = avs_write_i && ack;
    assign idx = avs_address_i[ADDR_W-1:2];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    always_comb begin
        mapped = 1'b1;
        notch_hit = 1'b0;
        notch_sel = 2'h0;
        cur_value = 9'h000;
        unique case (idx)
            IDX_LIM_TIMING: begin
                cur_value = lim_timing;
            end
            IDX_LIM_THRESH_BOOST: begin
                cur_value = lim_thresh_boost;
            end
            IDX_NOTCH_A0_HIGH_CTRL, IDX_NOTCH_A0_LOW, IDX_NOTCH_A1_HIGH, IDX_NOTCH_A1_LOW: begin
                notch_hit = 1'b1;
                notch_sel = 2'(idx - IDX_NOTCH_A0_HIGH_CTRL);
                cur_value = {1'b0, notch_pending[notch_sel]};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    assign merged = merge_lanes(cur_value, avs_writedata_i, avs_byteenable_i);
    assign update_req = avs_byteenable_i[1] && avs_writedata_i[UPDATE_BIT];

    // read data is captured on the wait cycle and stands while waitrequest is low
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            avs_readdata_o <= '0;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= mapped ? {{(BUS_W-DATA_W){1'b0}}, cur_value} : '0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lim_timing <= RST_LIM_TIMING;
        end else if (accept_wr && idx == IDX_LIM_TIMING) begin
            lim_timing <= merged & MASK_LIM_TIMING;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lim_thresh_boost <= RST_LIM_THRESH_BOOST;
        end else if (accept_wr && idx == IDX_LIM_THRESH_BOOST) begin
            lim_thresh_boost <= merged & MASK_LIM_THRESH_BOOST;
        end
    end

    assign lim_cfg = '{enable: lim_timing[LIM_EN_BIT],
                       decay_code: lim_timing[DECAY_LSB+:4],
                       attack_code: lim_timing[ATTACK_LSB+:4],
                       threshold_code: lim_thresh_boost[THRESH_LSB+:3],
                       boost_code: lim_thresh_boost[BOOST_LSB+:4]};

    dlnr_lim_decode u_lim_decode (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .cfg_i(lim_cfg),
        .lim_o(lim_o)
    );

    always_comb begin
        notch_wr = 4'h0;
        notch_wr[notch_sel] = accept_wr && notch_hit;
        notch_wdata = merged[7:0] & ((notch_sel == 2'h0) ? MASK_NOTCH_FIRST : MASK_NOTCH_OTHER);
    end

    dlnr_notch_bank u_notch_bank (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .wr_i(notch_wr),
        .wr_data_i(notch_wdata),
        .update_i(update_req),
        .pending_o(notch_pending),
        .active_o(notch_o)
    );

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic notch_commit;
    dlnr_notch_t pend_view;
    assign notch_commit = accept_wr && notch_hit && update_req;
    assign pend_view = '{enable: notch_pending[0][NOTCH_EN_BIT],
                         a0: {notch_pending[0][6:0], notch_pending[1][6:0]},
                         a1: {notch_pending[2][6:0], notch_pending[3][6:0]}};

    a_bus_one_wait: assert property (
        req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("access not answered after one wait cycle");

    a_reset_timing: assert property (
        $rose(arst_n_i) |-> lim_timing == 9'h032 && lim_o.attack_samples == 16'h000C)
        else $error("timing register reset value wrong");

    a_reset_zero: assert property (
        $rose(arst_n_i) |-> lim_thresh_boost == 9'h000 && notch_pending[1] == 8'h00
            && notch_pending[2] == 8'h00 && notch_pending[3] == 8'h00)
        else $error("zero reset registers not zero");

    a_decay_low: assert property (
        lim_cfg.decay_code == 4'h0 |=> lim_o.decay_samples == 16'h0018)
        else $error("decay base count wrong");

    a_decay_sat: assert property (
        lim_cfg.decay_code >= 4'hB |=> lim_o.decay_samples == 16'hC000)
        else $error("decay not saturated");

    a_decay_ten: assert property (
        lim_cfg.decay_code == 4'hA |=> lim_o.decay_samples == 16'h6000)
        else $error("decay code ten wrong");

    a_attack_sat: assert property (
        lim_cfg.attack_code >= 4'hB |=> lim_o.attack_samples == 16'h1800)
        else $error("attack not saturated");

    a_thresh_map: assert property (
        lim_cfg.threshold_code >= 3'h5 |=> lim_o.threshold_atten_db == 4'h6)
        else $error("threshold floor wrong");

    a_thresh_step: assert property (
        lim_cfg.threshold_code == 3'h3 |=> lim_o.threshold_atten_db == 4'h4)
        else $error("threshold step wrong");

    a_boost_top: assert property (
        lim_cfg.boost_code == 4'hC |=> lim_o.boost_ceiling_db == 4'hC)
        else $error("boost maximum wrong");

    a_fixed_gain: assert property (
        !lim_o.enable |-> lim_o.fixed_gain_db == lim_o.boost_ceiling_db)
        else $error("fixed gain missing while limiter off");

    // register lands at the write edge, decoder output one edge later
    a_limiter_on: assert property (
        accept_wr && idx == IDX_LIM_TIMING && avs_byteenable_i[1]
            |-> ##2 lim_o.enable == $past(avs_writedata_i[LIM_EN_BIT], 2))
        else $error("limiter enable not following write");

    a_notch_apply: assert property (
        notch_commit |=> notch_o == pend_view)
        else $error("notch set not applied together");

    a_notch_hold: assert property (
        !notch_commit |=> $stable(notch_o))
        else $error("notch active set changed without update");

    a_update_wo: assert property (
        avs_read_i && ack && notch_hit |-> avs_readdata_o[UPDATE_BIT] == 1'b0)
        else $error("update bit read back");

    a_a0_split: assert property (
        notch_commit |=> notch_o.a0[6:0] == notch_pending[1][6:0] && notch_o.a0[13:7] == notch_pending[0][6:0])
        else $error("A0 halves misplaced");

    c_notch_update: cover property (notch_commit);
    c_notch_pending: cover property (accept_wr && notch_hit && !update_req);
    c_notch_read: cover property (avs_read_i && ack && notch_hit);
    c_decay_sat: cover property (lim_cfg.decay_code == 4'hF && lim_cfg.enable);
endmodule : dlnr_regs
`default_nettype wire

// ### test/dlnr_regs_tb_top.sv
`default_nettype none
module dlnr_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dlnr_pkg::*;

    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [ADDR_W-1:0] address = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [BUS_W-1:0] wdata = '0;
    logic [3:0] be = 4'hF;
    logic [BUS_W-1:0] rdata;
    logic wait_req;
    dlnr_lim_out_t lim;
    dlnr_notch_t notch;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;

    dlnr_regs u_dlnr_regs (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .avs_address_i(address),
        .avs_read_i(rd),
        .avs_write_i(wr),
        .avs_writedata_i(wdata),
        .avs_byteenable_i(be),
        .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_req),
        .lim_o(lim),
        .notch_o(notch)
    );

    always #10 clk_i = ~clk_i;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // a hung handshake ends here; normal run takes well under 1000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            $display("ERROR %0t timeout", $time);
            finish_test();
        end
    end

    task automatic check_read(input logic [BUS_W-1:0] act, input logic [BUS_W-1:0] exp);
        check_count++;
        if (act !== exp) begin
            fails++;
            $display("ERROR %0t read got %h exp %h", $time, act, exp);
        end
    endtask : check_read

    task automatic check_port(input logic [63:0] act, input logic [63:0] exp);
        check_count++;
        if (act !== exp) begin
            fails++;
            $display("ERROR %0t output got %h exp %h", $time, act, exp);
        end
    endtask : check_port

    // request held until waitrequest is seen low at a rising edge
    task automatic bus_access(input logic is_wr, input logic [7:0] a, input logic [8:0] d,
                              input logic [3:0] lanes, output logic [BUS_W-1:0] q);
        @(posedge clk_i);
        address <= a;
        wdata <= {23'h0, d};
        be <= lanes;
        wr <= is_wr;
        rd <= !is_wr;
        do @(posedge clk_i); while (wait_req !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus_access

    task automatic wr_reg(input logic [7:0] a, input logic [8:0] d, input logic [3:0] lanes);
        logic [BUS_W-1:0] q;
        bus_access(1'b1, a, d, lanes, q);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [8:0] exp);
        logic [BUS_W-1:0] q;
        bus_access(1'b0, a, 9'h000, 4'hF, q);
        check_read(q, {23'h0, exp});
    endtask : rd_chk

    // limiter outputs are registered one cycle behind the register write; notch outputs change at the write edge
    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask : settle

    function automatic dlnr_lim_out_t lim_exp(input logic en, input logic [3:0] dc, input logic [3:0] at,
                                              input logic [2:0] th, input logic [3:0] bs);
        dlnr_lim_out_t e;
        e.enable = en;
        e.decay_samples = 16'h0018 << ((dc > 4'hB) ? 4'hB : dc);
        e.attack_samples = 16'h0003 << ((at > 4'hB) ? 4'hB : at);
        e.threshold_atten_db = (th > 3'h4) ? 4'h6 : {1'b0, th} + 4'h1;
        e.boost_ceiling_db = (bs > 4'hC) ? 4'hC : bs;
        e.fixed_gain_db = en ? 4'h0 : e.boost_ceiling_db;
        return e;
    endfunction : lim_exp

    initial begin
        logic [7:0] reset_addrs [5];
        reset_addrs = '{8'h64, 8'h6C, 8'h70, 8'h74, 8'h78};
        repeat (3) @(posedge clk_i);
        arst_n_i <= 1'b1;
        #1;
        check_port(64'(lim), 64'(lim_exp(1'b0, 4'h3, 4'h2, 3'h0, 4'h0)));
        check_port(64'(notch), 64'h0);
        rd_chk(8'h60, 9'h032);
        foreach (reset_addrs[k]) begin
            rd_chk(reset_addrs[k], 9'h000);
        end
        for (int i = 0; i < 16; i++) begin
            wr_reg(8'h60, {1'b1, 4'(i), 4'(i)}, 4'h3);
            settle();
            check_port(64'(lim), 64'(lim_exp(1'b1, 4'(i), 4'(i), 3'h0, 4'h0)));
        end
        wr_reg(8'h60, 9'h032, 4'h3);
        // reserved bits 8:7 are written as ones and must read back as zero
        for (int i = 0; i < 16; i++) begin
            wr_reg(8'h64, {2'h3, 3'(i), 4'(i)}, 4'h3);
            settle();
            check_port(64'(lim), 64'(lim_exp(1'b0, 4'h3, 4'h2, 3'(i), 4'(i))));
            rd_chk(8'h64, {2'h0, 3'(i), 4'(i)});
        end
        wr_reg(8'h60, 9'h132, 4'h3);
        settle();
        check_port(64'(lim), 64'(lim_exp(1'b1, 4'h3, 4'h2, 3'h7, 4'hF)));
        wr_reg(8'h6C, 9'h0D5, 4'h3);
        wr_reg(8'h70, 9'h02A, 4'h3);
        wr_reg(8'h74, 9'h011, 4'h3);
        // update bit set but its byte lane disabled: low byte stays pending, active set unchanged
        wr_reg(8'h78, 9'h133, 4'h1);
        settle();
        check_port(64'(notch), 64'h0);
        rd_chk(8'h6C, 9'h0D5);
        wr_reg(8'h78, 9'h133, 4'h3);
        settle();
        check_port(64'(notch), 64'({1'b1, 7'h55, 7'h2A, 7'h11, 7'h33}));
        rd_chk(8'h78, 9'h033);
        wr_reg(8'h70, 9'h001, 4'h3);
        settle();
        check_port(64'(notch), 64'({1'b1, 7'h55, 7'h2A, 7'h11, 7'h33}));
        wr_reg(8'h6C, 9'h17F, 4'h3);
        settle();
        check_port(64'(notch), 64'({1'b0, 7'h7F, 7'h01, 7'h11, 7'h33}));
        rd_chk(8'h6C, 9'h07F);
        wr_reg(8'h68, 9'h1FF, 4'hF);
        rd_chk(8'h68, 9'h000);
        rd_chk(8'h7C, 9'h000);
        finish_test();
    end
endmodule : dlnr_regs_tb_top
`default_nettype wire
